// ==== src/dsrsl_pkg.sv ====
// constants and types of the receive status latch bank
package dsrsl_pkg;

  // ---------------------------------------------------------------
  // register bus and map
  // ---------------------------------------------------------------
  localparam int AW = 10;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFF_CTRL  = 10'h120;
  localparam logic [AW-1:0] OFF_STAT1 = 10'h124;
  localparam logic [AW-1:0] OFF_STAT2 = 10'h126;
  localparam logic [AW-1:0] OFF_LAT1  = 10'h128;
  localparam logic [AW-1:0] OFF_LAT2  = 10'h12a;
  localparam logic [AW-1:0] OFF_IE1   = 10'h12c;
  localparam logic [AW-1:0] OFF_IE2   = 10'h12e;

  // ---------------------------------------------------------------
  // field masks and reset values
  // ---------------------------------------------------------------
  localparam logic [DW-1:0] ZERO16     = 16'h0000;
  localparam logic [DW-1:0] IE1_MASK   = 16'h0fff;
  localparam logic [DW-1:0] IE2_MASK   = 16'h0f0f;
  localparam logic [DW-1:0] LAT2_M23   = 16'h0c0c;
  localparam logic [DW-1:0] STAT2_M23  = 16'h000c;
  localparam logic [DW-1:0] FM_MASK    = 16'h0800;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  localparam int B_FM        = 11;
  localparam int B_IDENT     = 10;
  localparam int B_IDLE      = 9;
  localparam int B_ONES      = 8;
  localparam int B_MF        = 7;
  localparam int B_SEVERE    = 6;
  localparam int B_ALIGN     = 5;
  localparam int B_FRLOST    = 4;
  localparam int B_REMOTE    = 3;
  localparam int B_ALARM     = 2;
  localparam int B_FROUT     = 1;
  localparam int B_SIGLOST   = 0;
  localparam int B2_CPE      = 11;
  localparam int B2_FBE      = 10;
  localparam int B2_PE       = 9;
  localparam int B2_FE       = 8;
  localparam int B2_CBIT_NZ  = 3;
  localparam int B2_FAR_NZ   = 2;
  localparam int B2_PBIT_NZ  = 1;
  localparam int B2_FRAME_NZ = 0;
  localparam int C_M23    = 0;
  localparam int C_GEN    = 1;
  localparam int C_SEL_LO = 8;
  localparam int C_SEL_HI = 9;

  // framing event kind that feeds the framing error count
  typedef enum logic [1:0] {SEL_OUT, SEL_MF, SEL_F, SEL_M} dsrsl_fsel_t;

  // live receive conditions from the framer
  typedef struct packed {
    logic format_mismatch;
    logic app_ident_channel;
    logic idle;
    logic unframed_ones_seen;
    logic multiframe_lost;
    logic severe_frame_errors;
    logic frame_lost;
    logic remote_defect;
    logic alarm_indication;
    logic frame_out;
    logic signal_lost;
  } dsrsl_cond_t;

  // nonzero flags of the external error counters
  typedef struct packed {
    logic cbit_parity_count_nonzero;
    logic far_block_count_nonzero;
    logic pbit_parity_count_nonzero;
    logic frame_error_count_nonzero;
  } dsrsl_cnt_t;

  // one-cycle error and alignment events
  typedef struct packed {
    logic alignment_change;
    logic cbit_parity_error;
    logic far_block_error;
    logic pbit_parity_error;
    logic mbit_error;
    logic fbit_error;
  } dsrsl_evt_t;

  typedef struct packed {
    dsrsl_fsel_t frame_error_type_select;
    logic        port_status_global_enable;
    logic        m23_mode;
  } dsrsl_ctrl_t;

  typedef struct packed {
    dsrsl_cond_t   cond_prev;
    dsrsl_cnt_t    cnt_prev;
    logic          armed;
    dsrsl_ctrl_t   ctrl;
    logic [DW-1:0] lat1;
    logic [DW-1:0] lat2;
    logic [DW-1:0] ie1;
    logic [DW-1:0] ie2;
    logic [DW-1:0] rd_data;
    logic          req;
  } dsrsl_state_t;

endpackage

// ==== src/dsrsl_bank.sv ====
// receive status, latched event and interrupt enable register bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
module dsrsl_bank (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [dsrsl_pkg::AW-1:0] addr,
  input  wire logic                     wr_en,
  input  wire logic [dsrsl_pkg::DW-1:0] wr_data,
  input  wire logic                     rd_en,
  input  wire dsrsl_pkg::dsrsl_cond_t   conds,
  input  wire dsrsl_pkg::dsrsl_cnt_t    counts,
  input  wire dsrsl_pkg::dsrsl_evt_t    events,
  output logic      [dsrsl_pkg::DW-1:0] rd_data,
  output logic                          port_status_req,
  output dsrsl_pkg::dsrsl_fsel_t        frame_error_type_select
);
  import dsrsl_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // condition flags in status/latch1 layout, bit 5 unused
  function automatic logic [DW-1:0] cond_vec(input dsrsl_cond_t c);
    cond_vec = {4'h0, c.format_mismatch, c.app_ident_channel, c.idle,
                c.unframed_ones_seen, c.multiframe_lost,
                c.severe_frame_errors, 1'b0, c.frame_lost,
                c.remote_defect, c.alarm_indication, c.frame_out,
                c.signal_lost};
  endfunction

  // counter nonzero flags in the low nibble
  function automatic logic [DW-1:0] cnt_vec(input dsrsl_cnt_t c);
    cnt_vec = {12'h000, c.cbit_parity_count_nonzero,
               c.far_block_count_nonzero, c.pbit_parity_count_nonzero,
               c.frame_error_count_nonzero};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dsrsl_state_t  st_q;
  dsrsl_state_t  st_d;
  logic [DW-1:0] cur1;
  logic [DW-1:0] old1;
  logic [DW-1:0] set1;
  logic [DW-1:0] set2;
  logic [DW-1:0] clr1;
  logic [DW-1:0] clr2;
  logic [DW-1:0] crise;
  logic          fe_evt;
  logic          req_cause;

  // request cause from the current latches and enables
  // enables gated by global
  assign req_cause = st_q.ctrl.port_status_global_enable &
                     (|((st_q.lat1 & st_q.ie1) | (st_q.lat2 & st_q.ie2)));

  // next state
  always_comb
  begin
    st_d  = st_q;
    cur1  = cond_vec(conds);
    old1  = cond_vec(st_q.cond_prev);
    clr1  = ZERO16;
    clr2  = ZERO16;
    crise = st_q.armed ? (cnt_vec(counts) & ~cnt_vec(st_q.cnt_prev))
                       : ZERO16;
    set1 = st_q.armed ? (cur1 ^ old1) & ~FM_MASK : ZERO16;
    set1 = set1 | (st_q.armed ? (cur1 & ~old1 & FM_MASK) : ZERO16);
    set1[B_ALIGN] = events.alignment_change;
    unique case (st_q.ctrl.frame_error_type_select)
      SEL_OUT: fe_evt = st_q.armed & conds.frame_out &
                        ~st_q.cond_prev.frame_out;
      SEL_MF:  fe_evt = events.mbit_error | events.fbit_error;
      SEL_F:   fe_evt = events.fbit_error;
      SEL_M:   fe_evt = events.mbit_error;
    endcase
    set2 = ZERO16;
    set2[B2_CPE] = events.cbit_parity_error;
    set2[B2_FBE] = events.far_block_error;
    set2[B2_PE]  = events.pbit_parity_error;
    set2[B2_FE]  = fe_evt;
    set2 = set2 | crise;
    // register writes
    if (wr_en)
    begin
      unique case (addr)
        OFF_CTRL:
        begin
          st_d.ctrl.m23_mode = wr_data[C_M23];
          st_d.ctrl.port_status_global_enable = wr_data[C_GEN];
          st_d.ctrl.frame_error_type_select =
            dsrsl_fsel_t'(wr_data[C_SEL_HI:C_SEL_LO]);
        end
        OFF_LAT1: clr1 = wr_data;
        OFF_LAT2: clr2 = wr_data;
        OFF_IE1:  st_d.ie1 = wr_data & IE1_MASK;
        OFF_IE2:  st_d.ie2 = wr_data & IE2_MASK;
        default:  st_d.ctrl = st_q.ctrl; // others ignored
      endcase
    end
    st_d.lat1 = (st_q.lat1 & ~clr1) | set1;
    st_d.lat2 = (st_q.lat2 & ~clr2) | set2;
    if (st_d.ctrl.m23_mode)
    begin
      st_d.lat2 = st_d.lat2 & ~LAT2_M23;
    end
    // read data for the next cycle only
    st_d.rd_data = ZERO16;
    if (rd_en)
    begin
      unique case (addr)
        OFF_CTRL:  st_d.rd_data = {6'h00,
                     st_q.ctrl.frame_error_type_select, 6'h00,
                     st_q.ctrl.port_status_global_enable,
                     st_q.ctrl.m23_mode};
        OFF_STAT1: st_d.rd_data = cur1;
        OFF_STAT2: st_d.rd_data = cnt_vec(counts) &
                     ~(st_q.ctrl.m23_mode ? STAT2_M23 : ZERO16);
        OFF_LAT1:  st_d.rd_data = st_q.lat1;
        OFF_LAT2:  st_d.rd_data = st_q.lat2;
        OFF_IE1:   st_d.rd_data = st_q.ie1;
        OFF_IE2:   st_d.rd_data = st_q.ie2;
        default:   st_d.rd_data = ZERO16;
      endcase
    end
    st_d.req       = req_cause;
    st_d.cond_prev = conds;
    st_d.cnt_prev  = counts;
    st_d.armed     = 1'b1;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs
  assign rd_data                 = st_q.rd_data;
  assign port_status_req         = st_q.req;
  assign frame_error_type_select = st_q.ctrl.frame_error_type_select;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // live status reads
  a_sig_live: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT1
    |=> rd_data[B_SIGLOST] == $past(conds.signal_lost))
    else $error("signal lost status wrong");

  a_cbit_stat_m23: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2 && st_q.ctrl.m23_mode
    |=> !rd_data[B2_CBIT_NZ])
    else $error("cbit count status not zero in M23");

  a_cbit_stat_live: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2 && !st_q.ctrl.m23_mode
    |=> rd_data[B2_CBIT_NZ] == $past(counts.cbit_parity_count_nonzero))
    else $error("cbit count status wrong");

  a_far_stat_m23: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2 && st_q.ctrl.m23_mode
    |=> !rd_data[B2_FAR_NZ])
    else $error("far block status not zero in M23");

  a_far_stat_live: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2 && !st_q.ctrl.m23_mode
    |=> rd_data[B2_FAR_NZ] == $past(counts.far_block_count_nonzero))
    else $error("far block status wrong");

  a_pbit_stat_live: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2
    |=> rd_data[B2_PBIT_NZ] == $past(counts.pbit_parity_count_nonzero))
    else $error("pbit count status wrong");

  a_frame_stat_live: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_STAT2
    |=> rd_data[B2_FRAME_NZ] == $past(counts.frame_error_count_nonzero))
    else $error("frame count status wrong");

  // condition change latching
  a_fm_nofall: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && !st_q.lat1[B_FM] && $fell(conds.format_mismatch)
    |=> !st_q.lat1[B_FM])
    else $error("mismatch latched on falling edge");

  a_fm_rise: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $rose(conds.format_mismatch) |=> st_q.lat1[B_FM])
    else $error("mismatch rise not latched");

  a_ident_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed &&
    conds.app_ident_channel != st_q.cond_prev.app_ident_channel
    |=> st_q.lat1[B_IDENT])
    else $error("ident channel change not latched");

  a_idle_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.idle) |=> st_q.lat1[B_IDLE])
    else $error("idle change not latched");

  a_ones_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.unframed_ones_seen)
    |=> st_q.lat1[B_ONES])
    else $error("unframed ones change not latched");

  a_mf_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.multiframe_lost) |=> st_q.lat1[B_MF])
    else $error("multiframe change not latched");

  a_sev_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.severe_frame_errors)
    |=> st_q.lat1[B_SEVERE])
    else $error("severe frame change not latched");

  a_frlost_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.frame_lost) |=> st_q.lat1[B_FRLOST])
    else $error("frame lost change not latched");

  a_remote_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.remote_defect)
    |=> st_q.lat1[B_REMOTE])
    else $error("remote defect change not latched");

  a_alarm_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.alarm_indication)
    |=> st_q.lat1[B_ALARM])
    else $error("alarm change not latched");

  a_frout_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.frame_out) |=> st_q.lat1[B_FROUT])
    else $error("frame out change not latched");

  a_sig_change: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $changed(conds.signal_lost) |=> st_q.lat1[B_SIGLOST])
    else $error("signal lost change not latched");

  a_align_set: assert property (@(posedge clk) disable iff (rst)
    events.alignment_change |=> st_q.lat1[B_ALIGN])
    else $error("alignment change not latched");

  // error event and count latching
  a_cpe_m23: assert property (@(posedge clk) disable iff (rst)
    st_q.ctrl.m23_mode |-> !st_q.lat2[B2_CPE] && !st_q.lat2[B2_CBIT_NZ])
    else $error("cbit latch set in M23");

  a_fbe_m23: assert property (@(posedge clk) disable iff (rst)
    st_q.ctrl.m23_mode |-> !st_q.lat2[B2_FBE] && !st_q.lat2[B2_FAR_NZ])
    else $error("far block latch set in M23");

  a_pe_set: assert property (@(posedge clk) disable iff (rst)
    events.pbit_parity_error |=> st_q.lat2[B2_PE] ##1
    (st_q.lat2[B2_PE] ||
     $past(wr_en && addr == OFF_LAT2 && wr_data[B2_PE])))
    else $error("pbit error not latched");

  a_fe_select: assert property (@(posedge clk) disable iff (rst)
    st_q.ctrl.frame_error_type_select == SEL_M && events.fbit_error &&
    !events.mbit_error && !st_q.lat2[B2_FE] && !wr_en
    |=> !st_q.lat2[B2_FE])
    else $error("unselected framing event latched");

  a_cbit_rise: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && !st_q.ctrl.m23_mode && !wr_en &&
    $rose(counts.cbit_parity_count_nonzero) |=> st_q.lat2[B2_CBIT_NZ])
    else $error("cbit count rise not latched");

  a_far_rise: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && !st_q.ctrl.m23_mode && !wr_en &&
    $rose(counts.far_block_count_nonzero) |=> st_q.lat2[B2_FAR_NZ])
    else $error("far count rise not latched");

  a_pbit_rise: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $rose(counts.pbit_parity_count_nonzero)
    |=> st_q.lat2[B2_PBIT_NZ])
    else $error("pbit count rise not latched");

  a_frame_rise: assert property (@(posedge clk) disable iff (rst)
    st_q.armed && $rose(counts.frame_error_count_nonzero)
    |=> st_q.lat2[B2_FRAME_NZ])
    else $error("frame count rise not latched");

  // request gating and latch1 set-over-clear priority

  a_fm_request: assert property (@(posedge clk) disable iff (rst)
    st_q.ctrl.port_status_global_enable && st_q.ie1[B_FM] &&
    st_q.lat1[B_FM] |=> port_status_req)
    else $error("mismatch request missing");

  a_gen_gate: assert property (@(posedge clk) disable iff (rst)
    !st_q.ctrl.port_status_global_enable |=> !port_status_req)
    else $error("request without global enable");

  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    wr_en && addr == OFF_LAT1 && wr_data[B_ALIGN] &&
    events.alignment_change |=> st_q.lat1[B_ALIGN])
    else $error("clear beat a new event");

  a_req_or: assert property (@(posedge clk) disable iff (rst)
    ##1 port_status_req == $past(req_cause))
    else $error("request not OR of enabled latches");

endmodule

// ==== verif/tb.sv ====
// self-checking testbench of the receive status latch bank
`timescale 1ns/1ns
module tb;
  import dsrsl_pkg::*;
  logic          clk;
  logic          rst;
  logic [AW-1:0] addr;
  logic          wr_en;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  dsrsl_cond_t   conds;
  dsrsl_cnt_t    counts;
  dsrsl_evt_t    events;
  logic [DW-1:0] rd_data;
  logic          port_status_req;
  dsrsl_fsel_t   fsel;
  int            n_fail;
  int            num_checks;
  logic [DW-1:0] d;
  logic [DW-1:0] v;
  logic [1:0]    s;
  logic          m;

  dsrsl_bank u_dut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .conds(conds), .counts(counts),
    .events(events), .rd_data(rd_data), .port_status_req(port_status_req),
    .frame_error_type_select(fsel));

  // ---------------------------------------------------------------
  // clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // cuts a hang short well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus cycles and comparisons
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [DW-1:0] exp,
                     input logic [DW-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    #1;
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %b got %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] dat);
    @(posedge clk);
    addr    <= a;
    wr_data <= dat;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [AW-1:0] a,
                       input logic [DW-1:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(what, exp, rd_data);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic clr();
    wr(OFF_LAT1, 16'hffff);
    wr(OFF_LAT2, 16'hffff);
  endtask

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  function automatic logic [DW-1:0] ctl(logic [1:0] fs, logic g, logic md);
    return {6'h00, fs, 6'h00, g, md};
  endfunction

  // latch2 bits set by one event pulse under a selection and mode
  function automatic logic [DW-1:0] evl2(int j, logic [1:0] fs, logic md);
    case (j)
      4: return md ? 16'h0000 : 16'h0800;
      3: return md ? 16'h0000 : 16'h0400;
      2: return 16'h0200;
      1: return (fs == 2'b01 || fs == 2'b11) ? 16'h0100 : 16'h0000;
      0: return (fs == 2'b01 || fs == 2'b10) ? 16'h0100 : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hc28c));
    rst = 1'b1; addr = '0; wr_en = 1'b0; wr_data = '0; rd_en = 1'b0;
    conds = '0; counts = '0; events = '0; n_fail = 0; num_checks = 0;
    tick(2);
    rst <= 1'b0;
    tick(3);
    rdchk("ie1 reset", OFF_IE1, ZERO16);
    rdchk("ie2 reset", OFF_IE2, ZERO16);
    rdchk("unmapped", 10'h13c, ZERO16);
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom());
      wr(OFF_IE1, v);
      rdchk("ie1", OFF_IE1, v & IE1_MASK);
      wr(OFF_IE2, v);
      rdchk("ie2", OFF_IE2, v & IE2_MASK);
    end
    wr(OFF_STAT1, 16'hffff);
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom());
      @(posedge clk);
      conds <= dsrsl_cond_t'(v[10:0]);
      rdchk("stat1", OFF_STAT1, {4'h0, v[10:5], 1'b0, v[4:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom());
      wr(OFF_CTRL, ctl(v[5:4], 1'b0, v[6]));
      counts <= dsrsl_cnt_t'(v[3:0]);
      rdchk("stat2", OFF_STAT2, {12'h0, v[3:0] & (v[6] ? 4'h3 : 4'hf)});
      chk("fsel", {14'h0, v[5:4]}, {14'h0, fsel});
    end
    wr(OFF_CTRL, ctl(2'b00, 1'b0, 1'b0));
    counts <= '0;
    conds  <= '0;
    tick(3);
    clr();
    for (int i = 0; i < 11; i++)
      for (int r = 1; r >= 0; r--)
      begin
        @(posedge clk);
        conds <= dsrsl_cond_t'(r != 0 ? (11'h1 << i) : 11'h0);
        tick(2);
        v = (i == 10 && r == 0) ? 16'h0 : 16'h1 << (i < 5 ? i : i + 1);
        rdchk("lat1 cond", OFF_LAT1, v);
        v = (i == 1 && r != 0) ? 16'h0100 : 16'h0000;
        rdchk("lat2 oof", OFF_LAT2, v);
        clr();
      end
    for (int k = 0; k < 8; k++)
    begin
      m = k[2];
      s = k[1:0];
      wr(OFF_CTRL, ctl(s, 1'b0, m));
      clr();
      for (int j = 0; j < 6; j++)
      begin
        @(posedge clk);
        events <= dsrsl_evt_t'(6'h1 << j);
        @(posedge clk);
        events <= '0;
        rdchk("lat2 evt", OFF_LAT2, evl2(j, s, m));
        rdchk("lat1 align", OFF_LAT1, j == 5 ? 16'h0020 : 16'h0000);
        clr();
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      m = k[2];
      wr(OFF_CTRL, ctl(2'b00, 1'b0, m));
      clr();
      @(posedge clk);
      counts <= dsrsl_cnt_t'(4'h1 << k[1:0]);
      tick(2);
      v = (m && k[1:0] >= 2) ? 16'h0 : 16'h1 << k[1:0];
      rdchk("lat2 rise", OFF_LAT2, v);
      clr();
      counts <= '0;
      tick(2);
      rdchk("lat2 fall", OFF_LAT2, ZERO16);
    end
    wr(OFF_CTRL, ctl(2'b01, 1'b0, 1'b0));
    clr();
    @(posedge clk);
    events <= dsrsl_evt_t'(6'h06);
    @(posedge clk);
    addr    <= OFF_LAT2;
    wr_data <= 16'h0300;
    wr_en   <= 1'b1;
    events  <= dsrsl_evt_t'(6'h04);
    @(posedge clk);
    wr_en  <= 1'b0;
    events <= '0;
    rdchk("set wins", OFF_LAT2, 16'h0200);
    clr();
    conds <= dsrsl_cond_t'(11'h001);
    tick(2);
    wr(OFF_IE1, 16'h0001);
    tick(3);
    chkb("req global off", 1'b0, port_status_req);
    wr(OFF_CTRL, ctl(2'b00, 1'b1, 1'b0));
    tick(3);
    chkb("req los", 1'b1, port_status_req);
    wr(OFF_IE1, 16'h0800);
    tick(3);
    chkb("req fm idle", 1'b0, port_status_req);
    @(posedge clk);
    conds <= dsrsl_cond_t'(11'h401);
    tick(4);
    chkb("req fm", 1'b1, port_status_req);
    wr(OFF_LAT1, 16'hffff);
    tick(3);
    chkb("req cleared", 1'b0, port_status_req);
    wr(OFF_IE2, 16'h0200);
    @(posedge clk);
    events <= dsrsl_evt_t'(6'h04);
    @(posedge clk);
    events <= '0;
    tick(3);
    chkb("req pbit", 1'b1, port_status_req);
    wr(OFF_LAT2, 16'hffff);
    tick(3);
    chkb("req pbit clr", 1'b0, port_status_req);
    finish_test();
  end
endmodule
